// ==== rtl/grf_pkg.sv ====
// Notes on behaviour
// - Balance flags for cells 6-10, RW, reset zero.
// - Full reset fires gauge and log resets.
// - Gauge reset fires every estimator clear together except charge termination.
// - Log reset strobe clears lifetime log, self-clears.
// - Wake strobe at 0x78 bit 3 wakes gauge.
// - Pack-status strobe bit 4 resets status, self-clears.
// - Pack-full strobe bit 8 resets full indication.
// - Pack-empty strobe bit 9 resets empty indication.
// - Bit 10 strobe resets average discharge current.
// - Bit 11 strobe resets discharge termination current.
// - Bit 12 strobe resets charge termination current.
// - Bit 13 strobe resets charge constant-current value.
// - Bit 14 strobe resets charge constant-voltage value.
// - Charge show bit exposes power, cell, factor.
// - Discharge show bit exposes maximum discharge power.
package grf_pkg;
    localparam logic [15:0] GRF_ADDR_BALANCE = 16'h0074;
    localparam logic [15:0] GRF_ADDR_RESETS = 16'h0076;
    localparam logic [15:0] GRF_ADDR_WAKE = 16'h0078;

    localparam logic [15:0] GRF_BALANCE_MASK = 16'h03E0;
    localparam logic [15:0] GRF_RESETS_MASK = 16'h7FB7;
    localparam logic [15:0] GRF_WAKE_MASK = 16'h0008;
    localparam logic [15:0] GRF_SHOW_MASK = 16'h0003;
    localparam logic [15:0] GRF_REG_RESET = 16'h0000;

    localparam int GRF_BAL_FIRST = 5;
    localparam int GRF_BAL_COUNT = 5;

    localparam int GRF_RST_FULL = 0;
    localparam int GRF_RST_GAUGE = 1;
    localparam int GRF_RST_LOG = 2;
    localparam int GRF_RST_STATUS = 4;
    localparam int GRF_RST_HEALTH = 5;
    localparam int GRF_RST_CHARGE_STATE = 7;
    localparam int GRF_RST_PACK_FULL = 8;
    localparam int GRF_RST_PACK_EMPTY = 9;
    localparam int GRF_RST_AVG_DIS = 10;
    localparam int GRF_RST_DIS_TERM = 11;
    localparam int GRF_RST_CHG_TERM = 12;
    localparam int GRF_RST_CHG_CC = 13;
    localparam int GRF_RST_CHG_CV = 14;

    localparam int GRF_WAKE_BIT = 3;
    localparam int GRF_CHG_SHOW_BIT = 0;
    localparam int GRF_DIS_SHOW_BIT = 1;
endpackage

// ==== rtl/grf_regs.sv ====
`timescale 1ns/10ps
// Balance flags, reset strobes, wake strobe and power show enables.
module grf_regs
    import grf_pkg::*;
#(
    parameter int POWER_WIDTH = 32,
    parameter int CELL_ID_WIDTH = 4,
    parameter int FACTOR_WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    output logic regRvalid,
    input wire logic chargePowerShowDefault,
    input wire logic dischargePowerShowDefault,
    input wire logic [POWER_WIDTH-1:0] maxChargePowerIn,
    input wire logic [CELL_ID_WIDTH-1:0] limitingCellIndexIn,
    input wire logic [FACTOR_WIDTH-1:0] limitingFactorIn,
    input wire logic [POWER_WIDTH-1:0] maxDischargePowerIn,
    output logic [GRF_BAL_COUNT-1:0] cellBalanceFlags,
    output logic gaugeResetPulse,
    output logic logClear,
    output logic packStatusClear,
    output logic healthClear,
    output logic chargeStateClear,
    output logic packFullClear,
    output logic packEmptyClear,
    output logic resistanceClear,
    output logic timeEstimateClear,
    output logic avgDischargeClear,
    output logic dischargeTermClear,
    output logic chargeTermClear,
    output logic chargeConstCurrentClear,
    output logic chargeConstVoltageClear,
    output logic wakeStrobe,
    output logic chargePowerShow,
    output logic dischargePowerShow,
    output logic [POWER_WIDTH-1:0] maxChargePower,
    output logic [CELL_ID_WIDTH-1:0] limitingCellIndex,
    output logic [FACTOR_WIDTH-1:0] limitingFactor,
    output logic [POWER_WIDTH-1:0] maxDischargePower
);
    logic hitBalance;
    logic hitResets;
    logic hitWake;
    logic [15:0] balanceReg;
    logic [15:0] next_balanceReg;
    logic [15:0] resetStrobes;
    logic [15:0] wakeStrobes;
    logic [15:0] next_regRdata;
    logic next_regRvalid;
    logic gaugeFire;
    logic logFire;
    logic next_gaugeResetPulse;
    logic next_logClear;
    logic next_packStatusClear;
    logic next_healthClear;
    logic next_chargeStateClear;
    logic next_packFullClear;
    logic next_packEmptyClear;
    logic next_resistanceClear;
    logic next_timeEstimateClear;
    logic next_avgDischargeClear;
    logic next_dischargeTermClear;
    logic next_chargeTermClear;
    logic next_chargeConstCurrentClear;
    logic next_chargeConstVoltageClear;
    logic next_wakeStrobe;
    logic [POWER_WIDTH-1:0] next_maxChargePower;
    logic [CELL_ID_WIDTH-1:0] next_limitingCellIndex;
    logic [FACTOR_WIDTH-1:0] next_limitingFactor;
    logic [POWER_WIDTH-1:0] next_maxDischargePower;

    assign hitBalance = regAddr == GRF_ADDR_BALANCE;
    assign hitResets = regAddr == GRF_ADDR_RESETS;
    assign hitWake = regAddr == GRF_ADDR_WAKE;

    // Balance flags: cells 1 to 5 live elsewhere and read zero here.
    always_comb begin
        next_balanceReg = balanceReg;
        if (regWrite && hitBalance) begin
            next_balanceReg = regWdata & GRF_BALANCE_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            balanceReg <= GRF_REG_RESET;
        end else begin
            balanceReg <= next_balanceReg;
        end
    end

    assign cellBalanceFlags =
        balanceReg[GRF_BAL_FIRST +: GRF_BAL_COUNT];

    grf_strobe #(
        .WIDTH(16),
        .MASK(GRF_RESETS_MASK)
    ) u_reset_strobes (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .writeHit(regWrite && hitResets),
        .writeData(regWdata),
        .strobe(resetStrobes)
    );

    grf_strobe #(
        .WIDTH(16),
        .MASK(GRF_WAKE_MASK)
    ) u_wake_strobe (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .writeHit(regWrite && hitWake),
        .writeData(regWdata),
        .strobe(wakeStrobes)
    );

    grf_show_init u_show (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .chargePowerShowDefault(chargePowerShowDefault),
        .dischargePowerShowDefault(dischargePowerShowDefault),
        .writeHit(regWrite && hitWake),
        .writeData(regWdata),
        .chargePowerShow(chargePowerShow),
        .dischargePowerShow(dischargePowerShow)
    );

    // The pulses are registered one stage after the strobe, so every clear
    // launched by one write leaves on the same edge.
    always_comb begin
        gaugeFire = resetStrobes[GRF_RST_GAUGE]
            | resetStrobes[GRF_RST_FULL];
        logFire = resetStrobes[GRF_RST_LOG]
            | resetStrobes[GRF_RST_FULL];
        next_gaugeResetPulse = gaugeFire;
        next_logClear = logFire;
        next_packStatusClear = gaugeFire
            | resetStrobes[GRF_RST_STATUS];
        next_healthClear = gaugeFire | resetStrobes[GRF_RST_HEALTH];
        next_chargeStateClear = gaugeFire
            | resetStrobes[GRF_RST_CHARGE_STATE];
        next_packFullClear = gaugeFire
            | resetStrobes[GRF_RST_PACK_FULL];
        next_packEmptyClear = gaugeFire
            | resetStrobes[GRF_RST_PACK_EMPTY];
        next_resistanceClear = gaugeFire;
        next_timeEstimateClear = gaugeFire;
        next_avgDischargeClear = gaugeFire
            | resetStrobes[GRF_RST_AVG_DIS];
        next_dischargeTermClear = gaugeFire
            | resetStrobes[GRF_RST_DIS_TERM];
        next_chargeTermClear = resetStrobes[GRF_RST_CHG_TERM];
        next_chargeConstCurrentClear = gaugeFire
            | resetStrobes[GRF_RST_CHG_CC];
        next_chargeConstVoltageClear = gaugeFire
            | resetStrobes[GRF_RST_CHG_CV];
        next_wakeStrobe = wakeStrobes[GRF_WAKE_BIT];
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            gaugeResetPulse <= 1'b0;
            logClear <= 1'b0;
            packStatusClear <= 1'b0;
            healthClear <= 1'b0;
            chargeStateClear <= 1'b0;
            packFullClear <= 1'b0;
            packEmptyClear <= 1'b0;
            resistanceClear <= 1'b0;
            timeEstimateClear <= 1'b0;
            avgDischargeClear <= 1'b0;
            dischargeTermClear <= 1'b0;
            chargeTermClear <= 1'b0;
            chargeConstCurrentClear <= 1'b0;
            chargeConstVoltageClear <= 1'b0;
            wakeStrobe <= 1'b0;
        end else begin
            gaugeResetPulse <= next_gaugeResetPulse;
            logClear <= next_logClear;
            packStatusClear <= next_packStatusClear;
            healthClear <= next_healthClear;
            chargeStateClear <= next_chargeStateClear;
            packFullClear <= next_packFullClear;
            packEmptyClear <= next_packEmptyClear;
            resistanceClear <= next_resistanceClear;
            timeEstimateClear <= next_timeEstimateClear;
            avgDischargeClear <= next_avgDischargeClear;
            dischargeTermClear <= next_dischargeTermClear;
            chargeTermClear <= next_chargeTermClear;
            chargeConstCurrentClear <= next_chargeConstCurrentClear;
            chargeConstVoltageClear <= next_chargeConstVoltageClear;
            wakeStrobe <= next_wakeStrobe;
        end
    end

    // Hidden results read as zero so a stale value is never mistaken
    // for a live one.
    always_comb begin
        next_maxChargePower = '0;
        next_limitingCellIndex = '0;
        next_limitingFactor = '0;
        next_maxDischargePower = '0;
        if (chargePowerShow) begin
            next_maxChargePower = maxChargePowerIn;
            next_limitingCellIndex = limitingCellIndexIn;
            next_limitingFactor = limitingFactorIn;
        end
        if (dischargePowerShow) begin
            next_maxDischargePower = maxDischargePowerIn;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            maxChargePower <= '0;
            limitingCellIndex <= '0;
            limitingFactor <= '0;
            maxDischargePower <= '0;
        end else begin
            maxChargePower <= next_maxChargePower;
            limitingCellIndex <= next_limitingCellIndex;
            limitingFactor <= next_limitingFactor;
            maxDischargePower <= next_maxDischargePower;
        end
    end

    // Read port: one cycle latency, unmapped addresses answer zero.
    always_comb begin
        next_regRvalid = regRead;
        next_regRdata = 16'h0000;
        if (regRead) begin
            unique case (1'b1)
                hitBalance: next_regRdata = balanceReg;
                hitResets: next_regRdata = resetStrobes;
                hitWake: begin
                    next_regRdata = wakeStrobes;
                    next_regRdata[GRF_CHG_SHOW_BIT] = chargePowerShow;
                    next_regRdata[GRF_DIS_SHOW_BIT] = dischargePowerShow;
                end
                default: next_regRdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            regRdata <= 16'h0000;
            regRvalid <= 1'b0;
        end else begin
            regRdata <= next_regRdata;
            regRvalid <= next_regRvalid;
        end
    end

    property p_balance_write;
        @(posedge clk_sys) disable iff (!reset_n)
        regWrite && hitBalance |=>
            cellBalanceFlags == $past(regWdata[9:5]);
    endproperty
    a_balance_write: assert property (p_balance_write)
        else $error("balance flags not written");

    property p_full_reset;
        @(posedge clk_sys) disable iff (!reset_n)
        regWrite && hitResets && regWdata[GRF_RST_FULL] |=>
            ##1 gaugeResetPulse && logClear;
    endproperty
    a_full_reset: assert property (p_full_reset)
        else $error("full reset did not fire both resets");

    property p_gauge_fanout;
        @(posedge clk_sys) disable iff (!reset_n)
        gaugeResetPulse |-> packStatusClear && healthClear
            && chargeStateClear && packFullClear && packEmptyClear
            && resistanceClear && timeEstimateClear && avgDischargeClear
            && dischargeTermClear && chargeConstCurrentClear
            && chargeConstVoltageClear;
    endproperty
    a_gauge_fanout: assert property (p_gauge_fanout)
        else $error("gauge reset missed a sub-clear");

    property p_log_pulse;
        @(posedge clk_sys) disable iff (!reset_n)
        regWrite && hitResets && regWdata[GRF_RST_LOG] |=>
            ##1 logClear ##1 !logClear || $past(regWrite, 2);
    endproperty
    a_log_pulse: assert property (p_log_pulse)
        else $error("log clear not a single pulse");

    property p_wake;
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(wakeStrobe) |-> $past(regWrite && hitWake
            && regWdata[GRF_WAKE_BIT], 2);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake pulse without a wake write");

    property p_empty_clear;
        @(posedge clk_sys) disable iff (!reset_n)
        regWrite && hitResets && regWdata[GRF_RST_PACK_EMPTY] |=>
            ##1 packEmptyClear;
    endproperty
    a_empty_clear: assert property (p_empty_clear)
        else $error("pack empty clear missing");

    property p_charge_term;
        @(posedge clk_sys) disable iff (!reset_n)
        chargeTermClear |-> $past(resetStrobes[GRF_RST_CHG_TERM]);
    endproperty
    a_charge_term: assert property (p_charge_term)
        else $error("charge termination clear without strobe");

    property p_charge_hidden;
        @(posedge clk_sys) disable iff (!reset_n)
        !chargePowerShow |=> maxChargePower == '0
            && limitingCellIndex == '0;
    endproperty
    a_charge_hidden: assert property (p_charge_hidden)
        else $error("charge power exposed while hidden");

    property p_discharge_shown;
        @(posedge clk_sys) disable iff (!reset_n)
        dischargePowerShow |=>
            maxDischargePower == $past(maxDischargePowerIn);
    endproperty
    a_discharge_shown: assert property (p_discharge_shown)
        else $error("discharge power not exposed");
endmodule

// ==== rtl/grf_show_init.sv ====
`timescale 1ns/10ps
// Show enables take their configured default once reset has released.
module grf_show_init
    import grf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic chargePowerShowDefault,
    input wire logic dischargePowerShowDefault,
    input wire logic writeHit,
    input wire logic [15:0] writeData,
    output logic chargePowerShow,
    output logic dischargePowerShow
);
    logic loaded;
    logic next_loaded;
    logic next_chargePowerShow;
    logic next_dischargePowerShow;

    // The defaults are straps, so they are caught by the clock, not reset.
    always_comb begin
        next_loaded = 1'b1;
        next_chargePowerShow = chargePowerShow;
        next_dischargePowerShow = dischargePowerShow;
        if (writeHit) begin
            next_chargePowerShow = writeData[GRF_CHG_SHOW_BIT];
            next_dischargePowerShow = writeData[GRF_DIS_SHOW_BIT];
        end else if (!loaded) begin
            next_chargePowerShow = chargePowerShowDefault;
            next_dischargePowerShow = dischargePowerShowDefault;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            loaded <= 1'b0;
            chargePowerShow <= 1'b0;
            dischargePowerShow <= 1'b0;
        end else begin
            loaded <= next_loaded;
            chargePowerShow <= next_chargePowerShow;
            dischargePowerShow <= next_dischargePowerShow;
        end
    end

    property p_default_load;
        @(posedge clk_sys) disable iff (!reset_n)
        !loaded && !writeHit |=>
            chargePowerShow == $past(chargePowerShowDefault);
    endproperty
    a_default_load: assert property (p_default_load)
        else $error("charge show default not loaded");
endmodule

// ==== rtl/grf_strobe.sv ====
`timescale 1ns/10ps
// Self-clearing strobe bits: a write of one holds for exactly one cycle.
module grf_strobe
    import grf_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] MASK = '1
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic writeHit,
    input wire logic [WIDTH-1:0] writeData,
    output logic [WIDTH-1:0] strobe
);
    logic [WIDTH-1:0] next_strobe;

    // Writing zero leaves a bit idle, so no write can cancel a pulse.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                next_strobe[i] = writeHit & writeData[i] & MASK[i];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            strobe <= '0;
        end else begin
            strobe <= next_strobe;
        end
    end

    property p_self_clear;
        @(posedge clk_sys) disable iff (!reset_n)
        (|strobe) && !writeHit |=> strobe == '0;
    endproperty
    a_self_clear: assert property (p_self_clear)
        else $error("strobe did not self-clear");
endmodule

// ==== tb/gauge_reset_and_flag_bits_tb.sv ====
`timescale 1ns/10ps
module gauge_reset_and_flag_bits_tb
    import grf_pkg::*;
();
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic regWrite, regRead, regRvalid;
    logic [15:0] regAddr, regWdata, regRdata;
    logic chargePowerShowDefault = 1'b1;
    logic dischargePowerShowDefault = 1'b0;
    logic [31:0] maxChargePowerIn = 32'h89AB_CDEF;
    logic [3:0] limitingCellIndexIn = 4'hA;
    logic [7:0] limitingFactorIn = 8'h5C;
    logic [31:0] maxDischargePowerIn = 32'h1234_5678;
    logic [4:0] cellBalanceFlags;
    logic gaugeResetPulse, logClear, packStatusClear, healthClear;
    logic chargeStateClear, packFullClear, packEmptyClear, resistanceClear;
    logic timeEstimateClear, avgDischargeClear, dischargeTermClear;
    logic chargeTermClear, chargeConstCurrentClear, chargeConstVoltageClear;
    logic wakeStrobe, chargePowerShow, dischargePowerShow;
    logic [31:0] maxChargePower, maxDischargePower;
    logic [3:0] limitingCellIndex;
    logic [7:0] limitingFactor;
    logic [14:0] clrVec;
    int errors = 0;
    int n_compared = 0;

    always #10 clk_sys = ~clk_sys;

    assign clrVec = {wakeStrobe, chargeConstVoltageClear,
        chargeConstCurrentClear, chargeTermClear, dischargeTermClear,
        avgDischargeClear, timeEstimateClear, resistanceClear,
        packEmptyClear, packFullClear, chargeStateClear, healthClear,
        packStatusClear, logClear, gaugeResetPulse};

    grf_host host_u (.clk_sys(clk_sys), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .regRvalid(regRvalid));

    grf_regs #(.POWER_WIDTH(32), .CELL_ID_WIDTH(4), .FACTOR_WIDTH(8)) dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .regRvalid(regRvalid),
        .chargePowerShowDefault(chargePowerShowDefault),
        .dischargePowerShowDefault(dischargePowerShowDefault),
        .maxChargePowerIn(maxChargePowerIn),
        .limitingCellIndexIn(limitingCellIndexIn),
        .limitingFactorIn(limitingFactorIn),
        .maxDischargePowerIn(maxDischargePowerIn),
        .cellBalanceFlags(cellBalanceFlags),
        .gaugeResetPulse(gaugeResetPulse), .logClear(logClear),
        .packStatusClear(packStatusClear), .healthClear(healthClear),
        .chargeStateClear(chargeStateClear), .packFullClear(packFullClear),
        .packEmptyClear(packEmptyClear), .resistanceClear(resistanceClear),
        .timeEstimateClear(timeEstimateClear),
        .avgDischargeClear(avgDischargeClear),
        .dischargeTermClear(dischargeTermClear),
        .chargeTermClear(chargeTermClear),
        .chargeConstCurrentClear(chargeConstCurrentClear),
        .chargeConstVoltageClear(chargeConstVoltageClear),
        .wakeStrobe(wakeStrobe), .chargePowerShow(chargePowerShow),
        .dischargePowerShow(dischargePowerShow),
        .maxChargePower(maxChargePower),
        .limitingCellIndex(limitingCellIndex),
        .limitingFactor(limitingFactor),
        .maxDischargePower(maxDischargePower));

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_read(input logic [15:0] addr, input logic [15:0] exp);
        logic [15:0] data;
        logic ok;
        host_u.read_reg(addr, data, ok);
        chk("read valid", 32'h1, {31'h0, ok});
        chk("read data", {16'h0, exp}, {16'h0, data});
    endtask

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic test_reset_values();
        chk_read(GRF_ADDR_BALANCE, 16'h0000);
        chk_read(GRF_ADDR_RESETS, 16'h0000);
        chk("charge show", 32'h1, {31'h0, chargePowerShow});
        chk("discharge show", 32'h0, {31'h0, dischargePowerShow});
        chk("clear outputs", 32'h0, {17'h0, clrVec});
        $display("test reset values done");
    endtask

    task automatic test_balance();
        host_u.write_reg(GRF_ADDR_BALANCE, 16'hFFFF);
        chk("balance flags", 32'h1F, {27'h0, cellBalanceFlags});
        chk_read(GRF_ADDR_BALANCE, 16'h03E0);
        host_u.write_reg(GRF_ADDR_BALANCE, 16'h0140);
        chk("balance flags", 32'h0A, {27'h0, cellBalanceFlags});
        chk_read(GRF_ADDR_BALANCE, 16'h0140);
        $display("test balance done");
    endtask

    // The pulse must appear in exactly one cycle with every bit together.
    task automatic strobe_case(input logic [15:0] addr,
                               input logic [15:0] data,
                               input logic [14:0] exp,
                               input logic [15:0] readBack);
        int hits;
        int stray;
        hits = 0;
        stray = 0;
        host_u.write_reg(addr, data);
        repeat (5) begin
            @(negedge clk_sys);
            if (exp !== 15'h0 && clrVec === exp) hits++;
            else if (clrVec !== 15'h0) stray++;
        end
        chk("pulse cycles", (exp == 15'h0) ? 32'h0 : 32'h1, hits);
        chk("stray pulses", 32'h0, stray);
        chk_read(addr, readBack);
    endtask

    task automatic test_strobes();
        strobe_case(GRF_ADDR_RESETS, 16'h0001, 15'h37FF, 16'h0);
        strobe_case(GRF_ADDR_RESETS, 16'h0002, 15'h37FD, 16'h0);
        strobe_case(GRF_ADDR_RESETS, 16'h0004, 15'h0002, 16'h0);
        strobe_case(GRF_ADDR_RESETS, 16'h0010, 15'h0004, 16'h0);
        strobe_case(GRF_ADDR_RESETS, 16'h0020, 15'h0008, 16'h0);
        strobe_case(GRF_ADDR_RESETS, 16'h0080, 15'h0010, 16'h0);
        strobe_case(GRF_ADDR_RESETS, 16'h0100, 15'h0020, 16'h0);
        strobe_case(GRF_ADDR_RESETS, 16'h0200, 15'h0040, 16'h0);
        strobe_case(GRF_ADDR_RESETS, 16'h0400, 15'h0200, 16'h0);
        strobe_case(GRF_ADDR_RESETS, 16'h0800, 15'h0400, 16'h0);
        strobe_case(GRF_ADDR_RESETS, 16'h1000, 15'h0800, 16'h0);
        strobe_case(GRF_ADDR_RESETS, 16'h2000, 15'h1000, 16'h0);
        strobe_case(GRF_ADDR_RESETS, 16'h4000, 15'h2000, 16'h0);
        strobe_case(GRF_ADDR_RESETS, 16'h6014, 15'h3006, 16'h0);
        strobe_case(GRF_ADDR_RESETS, 16'h0000, 15'h0000, 16'h0);
        strobe_case(GRF_ADDR_WAKE, 16'h0009, 15'h4000, 16'h0001);
        strobe_case(GRF_ADDR_WAKE, 16'h0001, 15'h0000, 16'h0001);
        $display("test strobes done");
    endtask

    task automatic test_show();
        chk("charge power", 32'h89AB_CDEF, maxChargePower);
        chk("cell index", 32'hA, {28'h0, limitingCellIndex});
        chk("factor", 32'h5C, {24'h0, limitingFactor});
        chk("discharge power", 32'h0, maxDischargePower);
        host_u.write_reg(GRF_ADDR_WAKE, 16'h0002);
        maxDischargePowerIn = 32'hFEDC_BA98;
        repeat (2) @(negedge clk_sys);
        chk("discharge power", 32'hFEDC_BA98, maxDischargePower);
        chk("charge power", 32'h0, maxChargePower);
        chk("cell index", 32'h0, {28'h0, limitingCellIndex});
        chk("factor", 32'h0, {24'h0, limitingFactor});
        chk_read(GRF_ADDR_WAKE, 16'h0002);
        $display("test show done");
    endtask

    task automatic test_unmapped_and_reset();
        host_u.write_reg(16'h007A, 16'hFFFF);
        chk_read(16'h007A, 16'h0000);
        chk_read(16'h0075, 16'h0000);
        chk_read(GRF_ADDR_BALANCE, 16'h0140);
        // A second reset with the straps swapped must reload both defaults.
        @(negedge clk_sys);
        chargePowerShowDefault = 1'b0;
        dischargePowerShowDefault = 1'b1;
        reset_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("charge show", 32'h0, {31'h0, chargePowerShow});
        chk("discharge show", 32'h1, {31'h0, dischargePowerShow});
        chk("balance flags", 32'h0, {27'h0, cellBalanceFlags});
        chk_read(GRF_ADDR_WAKE, 16'h0002);
        $display("test unmapped and reset done");
    endtask

    initial begin
        repeat (10) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        test_reset_values();
        test_balance();
        test_strobes();
        test_show();
        test_unmapped_and_reset();
        end_sim();
    end

    // The whole sequence takes well under a thousand cycles.
    initial begin
        #100us;
        errors++;
        end_sim();
    end
endmodule

// ==== tb/grf_host.sv ====
`timescale 1ns/10ps
// Register master standing in for the host controller.
module grf_host (
    input wire logic clk_sys,
    output logic regWrite,
    output logic regRead,
    output logic [15:0] regAddr,
    output logic [15:0] regWdata,
    input wire logic [15:0] regRdata,
    input wire logic regRvalid
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 16'h0000;
        regWdata = 16'h0000;
    end

    // Released lines show the inverse, so a stale value can never match.
    task automatic write_reg(input logic [15:0] addr,
                             input logic [15:0] data);
        @(negedge clk_sys);
        regWrite = 1'b1;
        regAddr = addr;
        regWdata = data;
        @(negedge clk_sys);
        regWrite = 1'b0;
        regAddr = ~addr;
        regWdata = ~data;
    endtask

    // The answer stands for the cycle after the read edge only.
    task automatic read_reg(input logic [15:0] addr,
                            output logic [15:0] data,
                            output logic ok);
        @(negedge clk_sys);
        regRead = 1'b1;
        regAddr = addr;
        @(negedge clk_sys);
        regRead = 1'b0;
        regAddr = ~addr;
        ok = regRvalid;
        data = regRdata;
    endtask
endmodule
